// ==== hdl/cfhp_regs.vh ====
// constants for the configuration and host port controller
`ifndef CFHP_REGS_VH
`define CFHP_REGS_VH
// register byte offsets on the control bus
`define CFHP_OFF_CTRL 12'h000
`define CFHP_OFF_STAT 12'h004
`define CFHP_OFF_ADDR 12'h008
`define CFHP_OFF_WDATA 12'h00C
`define CFHP_OFF_RDATA 12'h010
`define CFHP_OFF_CMD 12'h014
// control register fields
`define CFHP_CTRL_MODE 0
`define CFHP_CTRL_SCAN_HI 1
`define CFHP_CTRL_BURST 2
`define CFHP_CTRL_SZ_LO 3
`define CFHP_CTRL_SZ_HI 4
// command codes (bit 0 of command register)
`define CFHP_CMD_WRITE 1'b0
`define CFHP_CMD_READ 1'b1
// transfer size encodings
`define CFHP_TSZ_WORD 2'b00
`define CFHP_TSZ_BYTE 2'b01
`define CFHP_TSZ_HALF 2'b10
// status fields
`define CFHP_ST_BUSY 0
`define CFHP_ST_READY 1
`define CFHP_ST_INIT_LOW 2
`define CFHP_ST_HIGH_DC 3
`define CFHP_ST_LOW_DC 4
`define CFHP_ST_DONE 5
// peripheral status bit on the data bus
`define CFHP_RDY_BIT 7
// host address width and burst beats
`define CFHP_HA_W 18
`define CFHP_BEATS 3'd4
// last strobe count; strobe low time is one cycle more
`define CFHP_STRB_CYC 2'd2
// axi responses
`define CFHP_RESP_OK 2'b00
`define CFHP_RESP_SLVERR 2'b10
`endif

// ==== hdl/cfhp_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cfhp_sync #(
  parameter W = 1
) (
  clk_sys,
  rst_n,
  d,
  q
);
  input wire clk_sys;
  input wire rst_n;
  input wire [W-1:0] d;
  output reg [W-1:0] q;
  reg [W-1:0] meta_r;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // cfhp_sync

// ==== hdl/cfhp_ctrl.v ====
// controller driving the configuration and host processor port pins
// Notes on behaviour
// - hold scan clock or mode high during config
// - init held low keeps device waiting
// - selected when active-low low, active-high high
// - never both strobes; write wins
// - write strobe low captures D[7:0]
// - direction high read, low write
// - address bus carries low 18 bits
// - burst flag low for burst, high single
// - beat request asserted, dropped before end
// - size 01 byte, 10 half, 00 word
`timescale 1ns/1ps
`include "cfhp_regs.vh"
module cfhp_ctrl (
  clk_sys,
  rst_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  scan_clk_hold,
  select_active_low_n,
  select_active_high,
  rd_strobe_n,
  wr_strobe_n,
  host_transfer_strobe_n,
  host_read_not_write,
  host_address_bus,
  host_burst_flag_n,
  burst_beat_request_n,
  transfer_size_code,
  data_out,
  data_oe,
  data_in,
  init_in,
  init_out,
  init_oe,
  ready_in,
  high_during_config,
  low_during_config_n,
  host_transfer_ack_n,
  core_reset_low
);
  input wire clk_sys;
  input wire rst_n;
  input wire [11:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output reg s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output reg s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [11:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output reg s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  output reg scan_clk_hold;
  output reg select_active_low_n;
  output reg select_active_high;
  output reg rd_strobe_n;
  output reg wr_strobe_n;
  output reg host_transfer_strobe_n;
  output reg host_read_not_write;
  output reg [`CFHP_HA_W-1:0] host_address_bus;
  output reg host_burst_flag_n;
  output reg burst_beat_request_n;
  output reg [1:0] transfer_size_code;
  output reg [7:0] data_out;
  output reg data_oe;
  input wire [7:0] data_in;
  input wire init_in;
  output reg init_out;
  output reg init_oe;
  input wire ready_in;
  input wire high_during_config;
  input wire low_during_config_n;
  input wire host_transfer_ack_n;
  output reg core_reset_low;

  localparam ST_IDLE = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_STRB = 3'd2;
  localparam ST_WAIT_ACK = 3'd3;
  localparam ST_RELEASE = 3'd4;

  // ==========================================================
  // pin synchronisers
  wire [12:0] pin_raw;
  wire [12:0] pin_s;
  assign pin_raw = {data_in, init_in, ready_in, high_during_config,
    low_during_config_n, host_transfer_ack_n};
  cfhp_sync #(.W(13)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_s)
  );
  wire [7:0] data_s = pin_s[12:5];
  wire init_s = pin_s[4];
  wire ready_s = pin_s[3];
  wire hdc_s = pin_s[2];
  wire ldc_n_s = pin_s[1];
  wire ack_n_s = pin_s[0];
  // done only when both config markers say so
  wire cfg_done = !hdc_s && ldc_n_s;

  // ==========================================================
  // software registers
  reg [4:0] ctrl_r;
  reg [`CFHP_HA_W-1:0] addr_r;
  reg [31:0] wdata_r;
  reg [31:0] rdata_r;
  reg go_r;
  reg go_dir_r;
  reg busy_r;
  reg [2:0] state_r;
  reg [1:0] cnt_r;
  reg [2:0] beat_r;
  reg aw_got_r;
  reg w_got_r;
  reg [11:0] aw_addr_r;
  reg [31:0] w_data_r;

  function [31:0] rd_mux;
    input [11:0] a;
    begin
      case (a)
        `CFHP_OFF_CTRL: rd_mux = {27'h000_0000, ctrl_r};
        `CFHP_OFF_STAT: rd_mux = {26'h000_0000, cfg_done, ldc_n_s, hdc_s,
          !init_s, ready_s, busy_r};
        `CFHP_OFF_ADDR: rd_mux = {14'h0000, addr_r};
        `CFHP_OFF_WDATA: rd_mux = wdata_r;
        `CFHP_OFF_RDATA: rd_mux = rdata_r;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `CFHP_OFF_CTRL) || (a == `CFHP_OFF_STAT) ||
        (a == `CFHP_OFF_ADDR) || (a == `CFHP_OFF_WDATA) ||
        (a == `CFHP_OFF_RDATA) || (a == `CFHP_OFF_CMD);
    end
  endfunction

  wire do_wr = aw_got_r && w_got_r && !s_axi_bvalid;

  // write path: address and data taken in either order
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFHP_RESP_OK;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      ctrl_r <= 5'h02;
      addr_r <= {`CFHP_HA_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      go_r <= 1'b0;
      go_dir_r <= `CFHP_CMD_WRITE;
    end else begin
      go_r <= 1'b0;
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_r) ? `CFHP_RESP_OK : `CFHP_RESP_SLVERR;
        case (aw_addr_r)
          `CFHP_OFF_CTRL: ctrl_r <= w_data_r[4:0];
          `CFHP_OFF_ADDR: addr_r <= w_data_r[`CFHP_HA_W-1:0];
          `CFHP_OFF_WDATA: wdata_r <= w_data_r;
          `CFHP_OFF_CMD: begin
            // a command while busy starts nothing, but its bit 0 still loads go_dir_r
            go_r <= !busy_r;
            go_dir_r <= w_data_r[0];
          end
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CFHP_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? `CFHP_RESP_OK : `CFHP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pin sequencer
  wire host_mode = ctrl_r[`CFHP_CTRL_MODE];
  wire burst_on = ctrl_r[`CFHP_CTRL_BURST];
  wire is_rd = (go_dir_r == `CFHP_CMD_READ);
  // waits out the device while init is held low or, outside host mode, not ready
  wire dev_free = init_s && (host_mode || ready_s);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 2'd0;
      beat_r <= 3'd0;
      busy_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      scan_clk_hold <= 1'b1;
      select_active_low_n <= 1'b1;
      select_active_high <= 1'b0;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      host_transfer_strobe_n <= 1'b1;
      host_read_not_write <= 1'b1;
      host_address_bus <= {`CFHP_HA_W{1'b0}};
      host_burst_flag_n <= 1'b1;
      burst_beat_request_n <= 1'b1;
      transfer_size_code <= `CFHP_TSZ_WORD;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      init_out <= 1'b0;
      init_oe <= 1'b0;
      core_reset_low <= 1'b0;
    end else begin
      core_reset_low <= 1'b1;
      // scan clock held high through configuration
      scan_clk_hold <= ctrl_r[`CFHP_CTRL_SCAN_HI] || !cfg_done;
      init_out <= 1'b0;
      init_oe <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (go_r) begin
            busy_r <= 1'b1;
            state_r <= ST_SETUP;
            beat_r <= 3'd0;
          end
        end
        ST_SETUP: begin
          if (dev_free) begin
            select_active_low_n <= 1'b0;
            select_active_high <= 1'b1;
            host_read_not_write <= is_rd;
            host_address_bus <= addr_r;
            transfer_size_code <= ctrl_r[`CFHP_CTRL_SZ_HI:`CFHP_CTRL_SZ_LO];
            host_burst_flag_n <= !(host_mode && burst_on);
            burst_beat_request_n <= !(host_mode && burst_on);
            // only drive data on writes: read leaves D to device
            data_oe <= !is_rd;
            data_out <= wdata_r[8*beat_r[1:0] +: 8];
            cnt_r <= 2'd0;
            state_r <= ST_STRB;
          end
        end
        ST_STRB: begin
          if (host_mode) begin
            host_transfer_strobe_n <= 1'b0;
            state_r <= ST_WAIT_ACK;
          end else begin
            // one strobe only: write wins, never both
            wr_strobe_n <= is_rd;
            rd_strobe_n <= !is_rd;
            cnt_r <= cnt_r + 2'd1;
            if (cnt_r == `CFHP_STRB_CYC) begin
              state_r <= ST_RELEASE;
            end
          end
        end
        ST_WAIT_ACK: begin
          if (!ack_n_s) begin
            if (is_rd) begin
              rdata_r[8*beat_r[1:0] +: 8] <= data_s;
            end
            beat_r <= beat_r + 3'd1;
            if (burst_on && beat_r + 3'd2 >= `CFHP_BEATS) begin
              burst_beat_request_n <= 1'b1;
            end
            if (!burst_on || beat_r + 3'd1 >= `CFHP_BEATS) begin
              state_r <= ST_RELEASE;
            end else begin
              data_out <= wdata_r[8*(beat_r[1:0] + 2'd1) +: 8];
            end
          end
        end
        ST_RELEASE: begin
          // status reaches data_s only two edges after the strobe fell
          if (!host_mode && is_rd) begin
            rdata_r <= {24'h00_0000, data_s};
          end
          rd_strobe_n <= 1'b1;
          wr_strobe_n <= 1'b1;
          host_transfer_strobe_n <= 1'b1;
          host_burst_flag_n <= 1'b1;
          burst_beat_request_n <= 1'b1;
          select_active_low_n <= 1'b1;
          select_active_high <= 1'b0;
          data_oe <= 1'b0;
          busy_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // cfhp_ctrl

// ==== test/cfhp_ctrl_sva.sv ====
// pin-side checker for the configuration and host port controller
`timescale 1ns/1ps
module cfhp_ctrl_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire select_active_low_n,
  input wire select_active_high,
  input wire rd_strobe_n,
  input wire wr_strobe_n,
  input wire host_transfer_strobe_n,
  input wire host_read_not_write,
  input wire host_burst_flag_n,
  input wire burst_beat_request_n,
  input wire [1:0] transfer_size_code,
  input wire data_oe,
  input wire init_in,
  input wire init_oe,
  input wire high_during_config,
  input wire scan_clk_hold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire sel = !select_active_low_n && select_active_high;
  wire hs = host_transfer_strobe_n;
  AST_NO_BOTH: assert property (rd_strobe_n || wr_strobe_n)
    else $error("both strobes low");
  AST_SEL: assert property (!(rd_strobe_n && wr_strobe_n && hs) |-> sel)
    else $error("strobe without select");
  AST_WR_PULSE: assert property ($fell(wr_strobe_n) |-> (!wr_strobe_n)[*3] ##1 wr_strobe_n)
    else $error("write strobe width");
  AST_RD_PULSE: assert property ($fell(rd_strobe_n) |-> (!rd_strobe_n)[*3] ##1 rd_strobe_n)
    else $error("read strobe width");
  AST_WR_DRIVE: assert property (!wr_strobe_n |-> data_oe)
    else $error("data not driven");
  AST_RD_FREE: assert property (!rd_strobe_n |-> !data_oe)
    else $error("data driven in read");
  AST_HOST_HOLD: assert property (!hs && !$past(hs) |-> $stable(host_read_not_write)
    && $stable(transfer_size_code)) else $error("host cycle changed");
  AST_HOST_MIN: assert property ($fell(hs) |-> (!hs)[*3])
    else $error("host strobe too short");
  AST_SIZE: assert property (!hs |-> transfer_size_code != 2'h3)
    else $error("bad size code");
  AST_BEAT: assert property (!burst_beat_request_n |-> !host_burst_flag_n)
    else $error("beat request outside burst");
  AST_INIT_WAIT: assert property ((!init_in)[*4] |-> rd_strobe_n && wr_strobe_n && hs)
    else $error("strobe while init low");
  AST_NO_PULL: assert property (!init_oe)
    else $error("init pulled");
  AST_SCAN: assert property (high_during_config[*4] |-> scan_clk_hold)
    else $error("scan hold low in config");
endmodule // cfhp_ctrl_chk
bind cfhp_ctrl cfhp_ctrl_chk chk (.*);

// ==== test/cfhp_dev_model.sv ====
// behavioural model of the configured device on the pin side
`timescale 1ns/1ps
module cfhp_dev_model #(parameter int CFG_BYTES = 4) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic init_in,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic host_transfer_strobe_n,
  input wire logic host_read_not_write,
  input wire logic [17:0] host_address_bus,
  input wire logic host_burst_flag_n,
  input wire logic [1:0] transfer_size_code,
  input wire logic [7:0] data_out,
  output logic [7:0] data_in,
  output logic init_pull,
  output logic ready_in,
  output logic high_during_config,
  output logic low_during_config_n,
  output logic host_transfer_ack_n = 1'b1
);
  logic [7:0] nbytes = 8'h00, bus_q = 8'h00, last_byte, h_byte;
  logic [17:0] h_addr;
  logic [1:0] h_size, beat = 2'h0;
  logic h_rw, h_burst, wr_q;
  logic [3:0] busy_cnt = 4'h0, init_cnt = 4'h8, ack_cnt = 4'h0;
  wire sel = !select_active_low_n && select_active_high;
  assign ready_in = busy_cnt == 4'h0;
  assign init_pull = init_cnt != 4'h0;
  // read strobe turns the upper lines into status at once; a write wins
  assign data_in = (sel && !rd_strobe_n && wr_strobe_n) ? {ready_in, 4'h5, bus_q[2:0]} : bus_q;
  assign high_during_config = nbytes < CFG_BYTES;
  assign low_during_config_n = !high_during_config;
  always @(posedge clk_sys) begin
    wr_q <= wr_strobe_n;
    host_transfer_ack_n <= 1'b1;
    // a released bus never holds its last value
    bus_q <= ~bus_q;
    if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
    if (init_cnt != 4'h0) init_cnt <= init_cnt - 4'h1;
    ack_cnt <= (sel && !host_transfer_strobe_n && ack_cnt != 4'h5) ? ack_cnt + 4'h1 : 4'h0;
    if (!sel) beat <= 2'h0;
    if (!rst_n) begin
      {nbytes, busy_cnt, init_cnt, bus_q} <= {8'h00, 4'h0, 4'h8, 8'h00};
    end else if (sel && !wr_strobe_n) begin
      if (wr_q && init_in) begin
        {last_byte, nbytes, busy_cnt} <= {data_out, nbytes + 8'h01, 4'h5};
      end
    end else if (ack_cnt == 4'h2) begin
      host_transfer_ack_n <= 1'b0;
      {h_addr, h_rw, h_size, h_burst} <= {host_address_bus, host_read_not_write,
        transfer_size_code, !host_burst_flag_n};
      if (host_read_not_write) bus_q <= 8'hA0 | beat;
      else h_byte <= data_out;
      beat <= beat + 2'h1;
    end
  end
endmodule // cfhp_dev_model

// ==== test/cfhp_ctrl_bench.sv ====
// self-checking bench for the configuration and host port controller
`timescale 1ns/1ps
`include "cfhp_regs.vh"
module cfhp_ctrl_bench;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [1:0] r;} cfhp_row_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, init_hold = 1'b0, init_pull;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, transfer_size_code, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic scan_clk_hold, select_active_low_n, select_active_high, rd_strobe_n, wr_strobe_n;
  logic host_transfer_strobe_n, host_read_not_write, host_burst_flag_n, burst_beat_request_n;
  logic [17:0] host_address_bus;
  logic [7:0] data_out, data_in;
  logic data_oe, init_in, init_out, init_oe, ready_in, high_during_config, low_during_config_n;
  logic host_transfer_ack_n, core_reset_low;
  int failures = 0, samples_checked = 0;
  cfhp_row_t rows [7] = '{'{1'b0, `CFHP_OFF_CTRL, 32'h0000_0002, 2'h0},
    '{1'b0, 12'h018, 32'h0000_0000, 2'h2}, '{1'b1, 12'h020, 32'h0000_0001, 2'h2},
    '{1'b1, `CFHP_OFF_ADDR, 32'h0003_1234, 2'h0}, '{1'b0, `CFHP_OFF_ADDR, 32'h0003_1234, 2'h0},
    '{1'b1, `CFHP_OFF_CTRL, 32'h0000_0000, 2'h0}, '{1'b0, `CFHP_OFF_CTRL, 32'h0000_0000, 2'h0}};
`define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, v); end end
  // open-drain init: low if anybody pulls
  assign init_in = !(init_pull || init_hold || (init_oe && !init_out));
  always #50 clk_sys = ~clk_sys;
  cfhp_ctrl dut (.*);
  cfhp_dev_model m (.*);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic stuck;
    failures++;
    complete_run;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    rs = 2'h3;
    for (n = 0; n < 50 && rs === 2'h3; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) rs = s_axi_bresp;
    end
    if (n == 50) stuck;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    rs = 2'h3;
    for (n = 0; n < 50 && rs === 2'h3; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) {v, rs} = {s_axi_rdata, s_axi_rresp};
    end
    if (n == 50) stuck;
  endtask
  task automatic idle;
    int n;
    d = 32'h0000_0001;
    for (n = 0; n < 100 && d[0] !== 1'b0; n++) rd(`CFHP_OFF_STAT, d, r);
    if (n == 100) stuck;
  endtask
  task automatic cmd(input logic [31:0] c, input logic rdback);
    wr(`CFHP_OFF_CTRL, c, r);
    wr(`CFHP_OFF_CMD, {31'h0, rdback}, r);
    idle;
    rd(`CFHP_OFF_RDATA, d, r);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    `CHK("core reset held", 1'b0, core_reset_low)
    rst_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    `CHK("core reset free", 1'b1, core_reset_low)
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, r);
      else begin
        rd(rows[i].a, d, r);
        `CHK("reg data", rows[i].d, d)
      end
      `CHK("reg resp", rows[i].r, r)
    end
    // second command lands while busy and must be dropped
    init_hold <= 1'b1;
    wr(`CFHP_OFF_WDATA, 32'h0000_005A, r);
    wr(`CFHP_OFF_CMD, 32'h0000_0000, r);
    wr(`CFHP_OFF_CMD, 32'h0000_0000, r);
    repeat (40) @(posedge clk_sys);
    `CHK("held bytes", 8'h00, m.nbytes)
    rd(`CFHP_OFF_STAT, d, r);
    `CHK("stat in config", 2'h1, d[4:3])
    init_hold <= 1'b0;
    idle;
    `CHK("one byte", 8'h01, m.nbytes)
    `CHK("byte", 8'h5A, m.last_byte)
    for (int i = 1; i < 4; i++) begin
      wr(`CFHP_OFF_WDATA, 32'h10 + i, r);
      cmd(32'h0000_0000, 1'b0);
      `CHK("byte", 8'h10 + i, m.last_byte)
    end
    rd(`CFHP_OFF_STAT, d, r);
    `CHK("stat done", 2'h2, d[4:3])
    `CHK("scan off", 1'b0, scan_clk_hold)
    cmd(32'h0000_0000, 1'b1);
    `CHK("status byte", 5'h15, d[7:3])
    for (logic [2:0] s = 0; s < 3; s++) begin
      wr(`CFHP_OFF_WDATA, {24'h0, 6'h30, s[1:0]}, r);
      cmd({27'h0, s[1:0], 3'h1}, 1'b0);
      `CHK("size", s[1:0], m.h_size)
      `CHK("host byte", {6'h30, s[1:0]}, m.h_byte)
      `CHK("host addr", 18'h3_1234, m.h_addr)
    end
    cmd(32'h0000_0009, 1'b1);
    `CHK("single read", 8'hA0, d[7:0])
    `CHK("single flag", 1'b0, m.h_burst)
    cmd(32'h0000_0005, 1'b1);
    `CHK("burst read", 32'hA3A2_A1A0, d)
    `CHK("burst flag", 1'b1, m.h_burst)
    complete_run;
  end
endmodule // cfhp_ctrl_bench
